// *** hw/dcf_top.sv ***
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
// Functional notes
// RQ1: 36-bit words, 512 deep, first-in first-out
// RQ2: transfers only on qualified rising clock edges
// RQ3: write and read on one edge both complete
// RQ4: input-ready and almost-full two-stage synchronised
// RQ5: output-ready and almost-empty two-stage synchronised
// RQ6: almost-empty low when count at most X
// RQ7: almost-full low when free at most Y
// RQ8: thresholds load from port A or serially
// RQ9: retransmit rereads words already read out
// RQ10: one flagged mailbox in each direction
// RQ11: 36-bit two-way data bus per port
// RQ12: full and empty flags plus threshold flags
// RQ13: input-ready low ignores writes, low in reset
// RQ14: select high blocks transfer, outputs float
// RQ15: qualifier high needed for any transfer
// RQ16: mailbox pick routes access to mailbox
// RQ17: output-ready only with data, else reads ignored
module dcf_top (
   input logic aclk,
   input logic aresetn,
   input logic port_a_select_n,
   input logic port_a_qualifier,
   input logic port_a_write,
   input logic port_a_mailbox_pick,
   input logic [dcf_pkg::DATA_W-1:0] side_a_bus_in,
   output logic [dcf_pkg::DATA_W-1:0] side_a_bus_out,
   output logic side_a_bus_oe,
   output logic input_ready_flag,
   output logic almost_full_flag_n,
   output logic mail_to_a_flag,
   input logic serial_enable_n,
   input logic serial_data,
   input logic port_b_select_n,
   input logic port_b_qualifier,
   input logic port_b_write,
   input logic port_b_mailbox_pick,
   input logic [dcf_pkg::DATA_W-1:0] side_b_bus_in,
   output logic [dcf_pkg::DATA_W-1:0] side_b_bus_out,
   output logic side_b_bus_oe,
   output logic output_ready_flag,
   output logic almost_empty_flag_n,
   output logic mail_to_b_flag,
   input logic [dcf_pkg::REG_AW-1:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [dcf_pkg::REG_DW-1:0] s_axi_wdata,
   input logic [dcf_pkg::STRB_W-1:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [dcf_pkg::REG_AW-1:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [dcf_pkg::REG_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   output logic irq
);
   import dcf_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic port_go(input logic sel_n, input logic qual);
      return !sel_n && qual;
   endfunction : port_go

   function automatic logic [REG_AW-1:0] word_addr(
      input logic [REG_AW-1:0] a);
      return {a[REG_AW-1:2], 2'h0};
   endfunction : word_addr

   function automatic logic is_mapped(input logic [REG_AW-1:0] a);
      logic [REG_AW-1:0] w;
      w = word_addr(a);
      return w == OFS_CTRL || w == OFS_XTHR || w == OFS_YTHR ||
             w == OFS_STATUS || w == OFS_MASK || w == OFS_LEVEL;
   endfunction : is_mapped

   function automatic logic [REG_DW-1:0] apply_strb(
      input logic [REG_DW-1:0] old, input logic [REG_DW-1:0] nw,
      input logic [STRB_W-1:0] strb);
      logic [REG_DW-1:0] r;
      r = old;
      for (int i = 0; i < STRB_W; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : apply_strb

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] wr_ptr_r, rd_ptr_r, mark_r;
   logic [CNT_W-1:0] count_c, used_c, free_c;
   logic full_c, empty_c, a_go, b_go, a_fifo_wr, b_fifo_rd;
   logic fifo_push, fifo_pop, retx_mode_r, retx_start, rewind_c;
   logic ld_x, ld_y, mb_b_set, mb_a_set, mb_b_clr, mb_a_clr;
   logic [ADDR_W-1:0] x_r, y_r;
   logic [DATA_W-1:0] mail_b_r, mail_a_r, ram_rd;
   logic [ST_W-1:0] status_r, mask_r, st_set;
   dcf_load_t load_st_r;
   logic aw_got_r, w_got_r, wr_commit, ctrl_wr, st_rd_clr;
   logic [REG_AW-1:0] aw_addr_r;
   logic [REG_DW-1:0] w_data_r, x_wval, y_wval, m_wval, rd_val;
   logic [STRB_W-1:0] w_strb_r;

   // ----------------------------------------------------------------
   // Port qualification and occupancy
   // ----------------------------------------------------------------
   assign a_go = port_go(port_a_select_n, port_a_qualifier); // RQ14 RQ15
   assign b_go = port_go(port_b_select_n, port_b_qualifier); // RQ2
   assign a_fifo_wr = a_go && port_a_write && !port_a_mailbox_pick; // RQ16
   assign b_fifo_rd = b_go && !port_b_write && !port_b_mailbox_pick;
   assign count_c = wr_ptr_r - rd_ptr_r;
   // In retransmit mode the marked words stay reserved
   assign used_c = wr_ptr_r - (retx_mode_r ? mark_r : rd_ptr_r);
   assign free_c = DEPTH - used_c;
   assign full_c = used_c == DEPTH; // RQ12
   assign empty_c = count_c == '0; // RQ12
   assign fifo_push = a_fifo_wr && input_ready_flag && !full_c &&
                      load_st_r == LD_IDLE; // RQ13
   assign fifo_pop = b_fifo_rd && output_ready_flag && !empty_c; // RQ17

   // ----------------------------------------------------------------
   // Storage array
   // ----------------------------------------------------------------
   dcf_ram u_ram (
      .aclk(aclk),
      .wr_en(fifo_push),
      .wr_addr(wr_ptr_r[ADDR_W-1:0]),
      .wr_data(side_a_bus_in),
      .rd_addr(rd_ptr_r[ADDR_W-1:0]),
      .rd_data(ram_rd)
   );

   // Write pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_r <= '0;
      end else if (fifo_push) begin
         wr_ptr_r <= wr_ptr_r + 10'h001; // RQ1
      end
   end

   // Read pointer and retransmit mark, push and pop on one edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr_r <= '0;
         mark_r <= '0;
      end else begin
         if (rewind_c) begin
            rd_ptr_r <= mark_r; // RQ9
         end else if (fifo_pop) begin
            rd_ptr_r <= rd_ptr_r + 10'h001; // RQ3
         end
         if (retx_start) begin
            mark_r <= rd_ptr_r; // RQ9
         end
      end
   end

   // ----------------------------------------------------------------
   // Flag synchronisers
   // ----------------------------------------------------------------
   dcf_sync2 u_sync_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({!full_c, free_c > {1'b0, y_r}}), // RQ4 RQ7
      .q({input_ready_flag, almost_full_flag_n})
   );

   dcf_sync2 u_sync_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({!empty_c, count_c > {1'b0, x_r}}), // RQ5 RQ6
      .q({output_ready_flag, almost_empty_flag_n})
   );

   // ----------------------------------------------------------------
   // Port data outputs
   // ----------------------------------------------------------------
   // Port A reads only its inbound mailbox
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         side_a_bus_out <= '0;
         side_a_bus_oe <= 1'b0;
      end else begin
         side_a_bus_oe <= !port_a_select_n && !port_a_write; // RQ11
         if (a_go && !port_a_write && port_a_mailbox_pick) begin
            side_a_bus_out <= mail_a_r; // RQ16
         end
      end
   end

   // Port B reads buffer or its inbound mailbox
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         side_b_bus_out <= '0;
         side_b_bus_oe <= 1'b0;
      end else begin
         side_b_bus_oe <= !port_b_select_n && !port_b_write; // RQ14
         if (b_go && !port_b_write && port_b_mailbox_pick) begin
            side_b_bus_out <= mail_b_r; // RQ16
         end else if (fifo_pop) begin
            side_b_bus_out <= ram_rd; // RQ1
         end
      end
   end

   // ----------------------------------------------------------------
   // Mailboxes
   // ----------------------------------------------------------------
   assign mb_b_set = a_go && port_a_write && port_a_mailbox_pick &&
                     !mail_to_b_flag;
   assign mb_a_set = b_go && port_b_write && port_b_mailbox_pick &&
                     !mail_to_a_flag;
   assign mb_b_clr = b_go && !port_b_write && port_b_mailbox_pick;
   assign mb_a_clr = a_go && !port_a_write && port_a_mailbox_pick;

   // Mail held until the far port reads it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mail_b_r <= '0;
         mail_a_r <= '0;
         mail_to_b_flag <= 1'b0;
         mail_to_a_flag <= 1'b0;
      end else begin
         if (mb_b_set) begin
            mail_b_r <= side_a_bus_in; // RQ10
            mail_to_b_flag <= 1'b1;
         end else if (mb_b_clr) begin
            mail_to_b_flag <= 1'b0;
         end
         if (mb_a_set) begin
            mail_a_r <= side_b_bus_in; // RQ10
            mail_to_a_flag <= 1'b1;
         end else if (mb_a_clr) begin
            mail_to_a_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Thresholds and control
   // ----------------------------------------------------------------
   assign ctrl_wr = wr_commit && word_addr(aw_addr_r) == OFS_CTRL &&
                    w_strb_r[0];
   assign retx_start = ctrl_wr && w_data_r[CTRL_RETX] && !retx_mode_r;
   assign rewind_c = ctrl_wr && w_data_r[CTRL_REWIND] && retx_mode_r;
   assign ld_x = a_fifo_wr && load_st_r == LD_X;
   assign ld_y = a_fifo_wr && load_st_r == LD_Y;
   assign x_wval = apply_strb(REG_DW'(x_r), w_data_r, w_strb_r);
   assign y_wval = apply_strb(REG_DW'(y_r), w_data_r, w_strb_r);
   assign m_wval = apply_strb(REG_DW'(mask_r), w_data_r, w_strb_r);

   // Retransmit mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         retx_mode_r <= 1'b0;
      end else if (ctrl_wr) begin
         retx_mode_r <= w_data_r[CTRL_RETX]; // RQ9
      end
   end

   // Parallel threshold load: next two port A writes give X then Y
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_st_r <= LD_IDLE;
      end else begin
         unique case (load_st_r)
            LD_IDLE: begin
               if (ctrl_wr && w_data_r[CTRL_ARM]) begin
                  load_st_r <= LD_X; // RQ8
               end
            end
            LD_X: begin
               if (a_fifo_wr) begin
                  load_st_r <= LD_Y;
               end
            end
            LD_Y: begin
               if (a_fifo_wr) begin
                  load_st_r <= LD_IDLE;
               end
            end
         endcase
      end
   end

   // Thresholds: bus write, then port A load, then serial shift
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         x_r <= XTHR_RST;
         y_r <= YTHR_RST;
      end else if (wr_commit && word_addr(aw_addr_r) == OFS_XTHR) begin
         x_r <= x_wval[ADDR_W-1:0];
      end else if (wr_commit && word_addr(aw_addr_r) == OFS_YTHR) begin
         y_r <= y_wval[ADDR_W-1:0];
      end else if (ld_x) begin
         x_r <= side_a_bus_in[ADDR_W-1:0]; // RQ8
      end else if (ld_y) begin
         y_r <= side_a_bus_in[ADDR_W-1:0]; // RQ8
      end else if (!serial_enable_n) begin
         {y_r, x_r} <= {y_r[ADDR_W-2:0], x_r, serial_data}; // RQ8
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   assign st_set = {b_fifo_rd && !fifo_pop,
                    a_fifo_wr && load_st_r == LD_IDLE && !fifo_push,
                    mb_a_set, mb_b_set};
   assign st_rd_clr = s_axi_arvalid && s_axi_arready &&
                      word_addr(s_axi_araddr) == OFS_STATUS;

   // Sticky status, cleared by read; a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~{ST_W{st_rd_clr}}) | st_set;
      end
   end

   // Mask and interrupt level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= MASK_RST;
         irq <= 1'b0;
      end else begin
         if (wr_commit && word_addr(aw_addr_r) == OFS_MASK) begin
            mask_r <= m_wval[ST_W-1:0];
         end
         irq <= |(status_r & mask_r);
      end
   end

   // ----------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------
   assign wr_commit = aw_got_r && w_got_r && !s_axi_bvalid;

   // Write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_got_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_commit) begin
         aw_got_r <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_got_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_commit) begin
         w_got_r <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read value decode
   always_comb begin
      rd_val = '0;
      case (word_addr(s_axi_araddr))
         OFS_CTRL: begin
            rd_val[CTRL_RETX] = retx_mode_r;
            rd_val[CTRL_ARM] = load_st_r != LD_IDLE;
         end
         OFS_XTHR: rd_val[ADDR_W-1:0] = x_r;
         OFS_YTHR: rd_val[ADDR_W-1:0] = y_r;
         OFS_STATUS: rd_val[ST_W-1:0] = status_r;
         OFS_MASK: rd_val[ST_W-1:0] = mask_r;
         OFS_LEVEL: begin
            rd_val[CNT_W-1:0] = count_c;
            rd_val[LVL_IR] = input_ready_flag;
            rd_val[LVL_OR] = output_ready_flag;
            rd_val[LVL_AF] = almost_full_flag_n;
            rd_val[LVL_AE] = almost_empty_flag_n;
            rd_val[LVL_MB_B] = mail_to_b_flag;
            rd_val[LVL_MB_A] = mail_to_a_flag;
         end
         default: rd_val = '0;
      endcase
   end

   // Read address and data channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_a_buf_wr;
      a_fifo_wr && load_st_r == LD_IDLE;
   endsequence
   sequence s_mb_b_wr;
      a_go && port_a_write && port_a_mailbox_pick && !mail_to_b_flag;
   endsequence
   sequence s_settled;
      $past(aresetn, 2) && $past(aresetn);
   endsequence

   property p_rq13;
      s_a_buf_wr ##0 !input_ready_flag |=> wr_ptr_r == $past(wr_ptr_r);
   endproperty
   a_rq13: assert property (p_rq13) else $error("write taken while not ready"); // RQ13
   property p_rq17;
      b_fifo_rd && !output_ready_flag && !rewind_c
         |=> rd_ptr_r == $past(rd_ptr_r);
   endproperty
   a_rq17: assert property (p_rq17) else $error("read taken while not ready"); // RQ17
   property p_rq4;
      s_settled |-> input_ready_flag == !$past(full_c, 2);
   endproperty
   a_rq4: assert property (p_rq4) else $error("input ready not 2-stage"); // RQ4
   property p_rq5;
      s_settled |-> output_ready_flag == !$past(empty_c, 2);
   endproperty
   a_rq5: assert property (p_rq5) else $error("output ready not 2-stage"); // RQ5
   property p_rq6;
      s_settled |-> almost_empty_flag_n == $past(count_c > {1'b0, x_r}, 2);
   endproperty
   a_rq6: assert property (p_rq6) else $error("almost empty wrong"); // RQ6
   property p_rq7;
      s_settled |-> almost_full_flag_n == $past(free_c > {1'b0, y_r}, 2);
   endproperty
   a_rq7: assert property (p_rq7) else $error("almost full wrong"); // RQ7
   property p_rq12;
      full_c [*3] |-> !input_ready_flag;
   endproperty
   a_rq12: assert property (p_rq12) else $error("full not flagged"); // RQ12
   property p_rq1;
      fifo_push && !fifo_pop && !rewind_c
         |=> count_c == $past(count_c) + 10'h001;
   endproperty
   a_rq1: assert property (p_rq1) else $error("count not advanced"); // RQ1
   property p_rq10;
      s_mb_b_wr |=> mail_to_b_flag && mail_b_r == $past(side_a_bus_in);
   endproperty
   a_rq10: assert property (p_rq10) else $error("mailbox not stored"); // RQ10
   property p_rq9;
      rewind_c |=> rd_ptr_r == $past(mark_r);
   endproperty
   a_rq9: assert property (p_rq9) else $error("rewind missed mark"); // RQ9
   property p_rq15;
      !port_b_qualifier && !rewind_c |=> rd_ptr_r == $past(rd_ptr_r);
   endproperty
   a_rq15: assert property (p_rq15) else $error("read without enable"); // RQ15
   property p_rq14;
      port_b_select_n |=> !side_b_bus_oe;
   endproperty
   a_rq14: assert property (p_rq14) else $error("bus driven unselected"); // RQ14

endmodule : dcf_top

// *** common/dcf_pkg.sv ***
package dcf_pkg;

   // ----------------------------------------------------------------
   // Data path and depth
   // ----------------------------------------------------------------
   localparam int DATA_W = 36;
   localparam int ADDR_W = 9;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] DEPTH = 10'h200;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam int REG_DW = 32;
   localparam int STRB_W = 4;
   localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] OFS_XTHR = 8'h04;
   localparam logic [REG_AW-1:0] OFS_YTHR = 8'h08;
   localparam logic [REG_AW-1:0] OFS_STATUS = 8'h0c;
   localparam logic [REG_AW-1:0] OFS_MASK = 8'h10;
   localparam logic [REG_AW-1:0] OFS_LEVEL = 8'h14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_RETX = 0;
   localparam int CTRL_ARM = 1;
   localparam int CTRL_REWIND = 2;
   localparam int ST_W = 4;
   localparam int ST_MB_B = 0;
   localparam int ST_MB_A = 1;
   localparam int ST_OVF = 2;
   localparam int ST_UNF = 3;
   localparam int LVL_IR = 16;
   localparam int LVL_OR = 17;
   localparam int LVL_AF = 18;
   localparam int LVL_AE = 19;
   localparam int LVL_MB_B = 20;
   localparam int LVL_MB_A = 21;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] XTHR_RST = 9'h008;
   localparam logic [ADDR_W-1:0] YTHR_RST = 9'h008;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;

   // Threshold load sequencing over port A
   typedef enum logic [1:0] {LD_IDLE, LD_X, LD_Y} dcf_load_t;

endpackage : dcf_pkg

// *** hw/dcf_sync2.sv ***
`timescale 1ns/1ns
module dcf_sync2 (
   input logic aclk,
   input logic aresetn,
   input logic [1:0] d,
   output logic [1:0] q
);
   import dcf_pkg::*;

   logic [1:0] meta_r;

   // Two-stage flag synchroniser, low during reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 2'h0;
         q <= 2'h0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : dcf_sync2

// *** hw/dcf_ram.sv ***
`timescale 1ns/1ns
module dcf_ram (
   input logic aclk,
   input logic wr_en,
   input logic [dcf_pkg::ADDR_W-1:0] wr_addr,
   input logic [dcf_pkg::DATA_W-1:0] wr_data,
   input logic [dcf_pkg::ADDR_W-1:0] rd_addr,
   output logic [dcf_pkg::DATA_W-1:0] rd_data
);
   import dcf_pkg::*;

   logic [DATA_W-1:0] mem [2**ADDR_W];

   // Write port
   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read port, registered by the caller
   assign rd_data = mem[rd_addr];

endmodule : dcf_ram

// *** dv/dcf_b_reader.sv ***
`timescale 1ns/1ns
// Port B consumer, paced so the lagging flags never overrun
module dcf_b_reader (
   input logic aclk,
   input logic aresetn,
   input logic stall,
   input logic output_ready_flag,
   output logic port_b_select_n,
   output logic port_b_qualifier,
   output logic port_b_write,
   output logic port_b_mailbox_pick
);
   logic [1:0] gap_r;
   // Selected only while a read is offered
   assign port_b_select_n = !port_b_qualifier;
   assign port_b_write = 1'b0;
   assign port_b_mailbox_pick = 1'b0;
   // One-edge read, then a gap for the flags to settle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= 2'h0;
         port_b_qualifier <= 1'b0;
      end else if (port_b_qualifier) begin
         port_b_qualifier <= 1'b0;
         gap_r <= 2'h3;
      end else if (gap_r != 2'h0) begin
         gap_r <= gap_r - 2'h1;
      end else begin
         port_b_qualifier <= output_ready_flag && !stall;
      end
   end
endmodule : dcf_b_reader

// *** dv/dual_clock_fifo_with_mailboxes_bench.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
$display("[ERR] %0t %h %h", $time, a, b); num_errors++; end end
module dual_clock_fifo_with_mailboxes_bench;
   import dcf_pkg::*;
   logic aclk, aresetn, port_a_select_n, port_a_qualifier, port_a_write;
   logic port_a_mailbox_pick, side_a_bus_oe, input_ready_flag, irq, stall;
   logic almost_full_flag_n, mail_to_a_flag, serial_enable_n, serial_data;
   logic port_b_select_n, port_b_qualifier, port_b_write, port_b_mailbox_pick;
   logic side_b_bus_oe, output_ready_flag, almost_empty_flag_n, mail_to_b_flag;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, rd_d, rd_dd;
   logic [DATA_W-1:0] side_a_bus_in, side_a_bus_out, side_b_bus_in;
   logic [DATA_W-1:0] side_b_bus_out, exp_w;
   logic [DATA_W-1:0] q[$], hq[$];
   logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [REG_DW-1:0] s_axi_wdata, s_axi_rdata, rd, seed;
   logic [STRB_W-1:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [63:0] rnd;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   dcf_top dcf_top_i (.*);
   dcf_b_reader dcf_b_reader_i (.*);

   // Clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Reference queue fed by accepted writes, read outcomes delayed
   always @(posedge aclk) begin
      if (aresetn && !port_a_select_n && port_a_qualifier && port_a_write &&
          !port_a_mailbox_pick && input_ready_flag) begin
         q.push_back(side_a_bus_in);
         hq.push_back(side_a_bus_in);
      end
      rd_dd <= rd_d;
      rd_d <= aresetn && !port_b_select_n && port_b_qualifier &&
              !port_b_write && output_ready_flag;
   end

   // Read data against the reference
   always @(negedge aclk) if (rd_dd) begin
      exp_w = q.pop_front();
      `CHK(side_b_bus_out, exp_w)
   end

   task automatic complete_run;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr

   // One port A write, qualifier high for one edge
   task automatic pa(input logic mb);
      rnd = {$random(seed), $random(seed)};
      @(posedge aclk);
      {port_a_select_n, port_a_qualifier} <= 2'h1;
      port_a_mailbox_pick <= mb;
      side_a_bus_in <= rnd[DATA_W-1:0];
      @(posedge aclk);
      {port_a_select_n, port_a_qualifier} <= 2'h2;
   endtask : pa

   // Main sequence
   initial begin
      seed = 32'ha2298b9f;
      {aresetn, port_a_qualifier, port_a_mailbox_pick, serial_data} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, side_a_bus_in, side_b_bus_in} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {port_a_select_n, port_a_write, serial_enable_n, stall} = 4'hf;
      s_axi_wstrb = 4'hf;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK(input_ready_flag, 1'b1)
      `CHK(output_ready_flag, 1'b0)
      axw(OFS_XTHR, 32'h3);
      axr(OFS_XTHR);
      `CHK(rd[8:0], 9'h003)
      for (int k = 0; k < 6; k++) begin
         pa(1'b0);
         repeat (4) @(posedge aclk);
         `CHK(almost_empty_flag_n, q.size() > 3)
         axr(OFS_LEVEL);
         `CHK(rd[9:0], 10'(q.size()))
      end
      `CHK(almost_full_flag_n, 1'b1)
      axw(OFS_YTHR, 32'h1fa);
      repeat (2) @(posedge aclk);
      `CHK(almost_full_flag_n, 1'b0)
      axw(OFS_CTRL, 32'h1);
      stall <= 1'b0;
      for (int k = 0; k < 6; k++) pa(1'b0);
      // Drain, rewind to the mark, then drain the same words again
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge aclk);
         repeat (6) @(posedge aclk);
         `CHK(output_ready_flag, 1'b0)
         `CHK(almost_empty_flag_n, 1'b0)
         if (p == 0) begin
            axw(OFS_CTRL, 32'h5);
            q = hq;
            axr(OFS_LEVEL);
            `CHK(rd[9:0], 10'(hq.size()))
         end
      end
      axw(OFS_MASK, 32'h1);
      pa(1'b1);
      repeat (3) @(posedge aclk);
      `CHK(mail_to_b_flag, 1'b1)
      `CHK(irq, 1'b1)
      axr(OFS_STATUS);
      `CHK(rd[3:0], 4'h1)
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      axr(8'h40);
      `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
      complete_run();
   end

   // Hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         complete_run();
      end
   end
endmodule : dual_clock_fifo_with_mailboxes_bench
